// File: dv/pwmt_load_model.sv
// pin load model: times high phase and period on every pwm pin
`timescale 1ns/1ps
`default_nettype none
module pwmt_load_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [6:1] pins,
  output var int high_len [6:1],
  output var int period_len [6:1]
);
  int since_rise [6:1];
  logic [6:1] last_q;
  // a passive load; it only reports high and period lengths, so it never drives the pins
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last_q <= '0;
      for (int i = 1; i <= 6; i++) begin
        since_rise[i] <= 0;
        high_len[i] <= 0;
        period_len[i] <= 0;
      end
    end else begin
      last_q <= pins;
      for (int i = 1; i <= 6; i++) begin
        // counts in clocks; both edges see the same sampling delay
        if (pins[i] === 1'b1 && last_q[i] === 1'b0) begin
          period_len[i] <= since_rise[i] + 1;
          since_rise[i] <= 0;
        end else begin
          since_rise[i] <= since_rise[i] + 1;
        end
        if (pins[i] === 1'b0 && last_q[i] === 1'b1) begin
          high_len[i] <= since_rise[i] + 1;
        end
      end
    end
  end
endmodule : pwmt_load_model
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench: ahb-lite register tests and pwm pin timing
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic [6:1] pwm_out;
  logic [31:0] rd;
  int hi [6:1];
  int per [6:1];
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;

  pwmt_top dut_u (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq), .pwm_out(pwm_out));
  pwmt_load_model load_u (.clk(clk), .reset_n(reset_n), .pins(pwm_out),
    .high_len(hi), .period_len(per));

  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  // hang guard: the whole sequence needs well under 2000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (failures == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // one single transfer; address phase held until hready, then data phase
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wr ? d : 32'h0000_0000;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : rd_chk

  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd_chk(pwmt_pkg::OFS_CTRL, 32'h0000_0000);
    rd_chk(pwmt_pkg::OFS_COUNT, 32'h0000_0000);
    rd_chk(8'h80, 32'h0000_0000);
    check({25'h0, irq, pwm_out}, 32'h0000_0000);
    // slave is always ready and answers okay
    check({30'h0, hresp, hreadyout}, 32'h0000_0001);
    // compares written and released in timer mode apply at once
    wr(pwmt_pkg::OFS_MATCH0, 32'h0000_0009);
    wr(pwmt_pkg::OFS_MATCH0 + 8'h04, 32'h0000_0004);
    wr(pwmt_pkg::OFS_MATCH0 + 8'h08, 32'h0000_0007);
    wr(pwmt_pkg::OFS_MATCH0 + 8'h0C, 32'h0000_0009);
    wr(pwmt_pkg::OFS_RELEASE, 32'h0000_000F);
    wr(pwmt_pkg::OFS_PRESCALE, 32'h0000_0001);
    rd_chk(pwmt_pkg::OFS_PRESCALE, 32'h0000_0001);
    // out2 double-edge, outputs 1..6 enabled, then pwm mode
    wr(pwmt_pkg::OFS_OUTCFG, 32'h0000_7E04);
    wr(pwmt_pkg::OFS_CTRL, 32'h0000_0009);
    repeat (80) @(posedge clk);
    // period (1+1)*(9+1) clocks; out1 high 5 steps, out2 3 steps
    check(32'(per[1]), 32'h0000_0014);
    check(32'(per[2]), 32'h0000_0014);
    check(32'(hi[1]), 32'h0000_000A);
    check(32'(hi[2]), 32'h0000_0006);
    check(32'(per[3]), 32'h0000_0000);
    // out4 edge at compare4 = 0: high for one step after each start
    check(32'(per[4]), 32'h0000_0014);
    check(32'(hi[4]), 32'h0000_0002);
    // an unreleased compare value must not change the pulse
    wr(pwmt_pkg::OFS_MATCH0 + 8'h04, 32'h0000_0006);
    repeat (60) @(posedge clk);
    check(32'(hi[1]), 32'd10);
    rd_chk(pwmt_pkg::OFS_MATCH0 + 8'h04, 32'h0000_0006);
    wr(pwmt_pkg::OFS_RELEASE, 32'h0000_0002);
    repeat (60) @(posedge clk);
    check(32'(hi[1]), 32'h0000_000E);
    // out2 now rises at 6 and falls at 7: one step of two clocks
    check(32'(hi[2]), 32'h0000_0002);
    // software counter reset parks counts and pins
    wr(pwmt_pkg::OFS_CTRL, 32'h0000_000B);
    repeat (3) @(posedge clk);
    check({26'h0, pwm_out}, 32'h0000_0000);
    rd_chk(pwmt_pkg::OFS_COUNT, 32'h0000_0000);
    rd_chk(pwmt_pkg::OFS_PRECOUNT, 32'h0000_0000);
    // timer mode: compare3 raises a flag and stops the count
    wr(pwmt_pkg::OFS_CTRL, 32'h0000_0000);
    wr(pwmt_pkg::OFS_ACTION, 32'h0000_0A00);
    wr(pwmt_pkg::OFS_MATCH0 + 8'h0C, 32'h0000_0005);
    wr(pwmt_pkg::OFS_RELEASE, 32'h0000_0008);
    wr(pwmt_pkg::OFS_CTRL, 32'h0000_0001);
    repeat (40) @(posedge clk);
    rd_chk(pwmt_pkg::OFS_CTRL, 32'h0000_0000);
    rd_chk(pwmt_pkg::OFS_STATUS, 32'h0000_0008);
    check({26'h0, pwm_out}, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    wr(pwmt_pkg::OFS_MASK, 32'h0000_0008);
    // the mask lands on the closing edge; look one clock later
    @(posedge clk);
    check({31'h0, irq}, 32'h0000_0001);
    wr(pwmt_pkg::OFS_STATUS, 32'h0000_0008);
    rd_chk(pwmt_pkg::OFS_STATUS, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    // compare4 clears the count: it never passes 3
    wr(pwmt_pkg::OFS_ACTION, 32'h0000_2000);
    wr(pwmt_pkg::OFS_MATCH0 + 8'h10, 32'h0000_0003);
    wr(pwmt_pkg::OFS_RELEASE, 32'h0000_0010);
    wr(pwmt_pkg::OFS_PRESCALE, 32'h0000_0000);
    // the stop left the count past 3; start it again from zero
    wr(pwmt_pkg::OFS_COUNT, 32'h0000_0000);
    wr(pwmt_pkg::OFS_CTRL, 32'h0000_0001);
    for (int k = 0; k < 8; k++) begin
      ahb(1'b0, pwmt_pkg::OFS_COUNT, 32'h0000_0000);
      check({31'h0, rd <= 32'h0000_0003}, 32'h0000_0001);
    end
    give_verdict();
  end
endmodule : testbench
`default_nettype wire

// File: logic/pwmt_match_bank.sv
// compare register bank: written shadows and released active values
`timescale 1ns/1ps
`default_nettype none
module pwmt_match_bank (
  input wire logic clk,
  input wire logic reset_n,
  pwmt_match_if.bank mif
);
  logic [6:0][31:0] shadow_q;
  logic [6:0][31:0] shadow_d;
  logic [6:0][31:0] active_q;
  logic [6:0][31:0] active_d;
  logic [31:0] rd_q;
  logic [31:0] rd_d;

  // shadows take writes at once; active copies move only on release
  always_comb begin
    shadow_d = shadow_q;
    active_d = active_q;
    rd_d = pwmt_pkg::RST_WORD;
    if (mif.wr_en && mif.wr_idx < 3'h7) begin
      shadow_d[mif.wr_idx] = mif.wr_data;
    end
    for (int i = 0; i < pwmt_pkg::NUM_MATCH; i++) begin
      if (mif.apply[i]) begin
        active_d[i] = shadow_d[i];
      end
    end
    // read port returns the written value, one cycle later
    if (mif.rd_idx < 3'h7) begin
      rd_d = shadow_q[mif.rd_idx];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shadow_q <= '0;
      active_q <= '0;
      rd_q <= pwmt_pkg::RST_WORD;
    end else begin
      shadow_q <= shadow_d;
      active_q <= active_d;
      rd_q <= rd_d;
    end
  end

  assign mif.active = active_q;
  assign mif.rd_data = rd_q;
endmodule : pwmt_match_bank
`default_nettype wire

// File: logic/pwmt_match_if.sv
// carrier between the control logic and the compare register bank
`timescale 1ns/1ps
`default_nettype none
interface pwmt_match_if;
  logic wr_en;
  logic [2:0] wr_idx;
  logic [31:0] wr_data;
  logic [6:0] apply;
  logic [2:0] rd_idx;
  logic [31:0] rd_data;
  logic [6:0][31:0] active;
  modport ctrl (output wr_en, wr_idx, wr_data, apply, rd_idx,
                input rd_data, active);
  modport bank (input wr_en, wr_idx, wr_data, apply, rd_idx,
                output rd_data, active);
endinterface : pwmt_match_if
`default_nettype wire

// File: logic/pwmt_pkg.sv
// constants shared by the match-based pwm timer modules
package pwmt_pkg;
  localparam int NUM_MATCH = 7;
  localparam int NUM_OUT = 6;
  // register byte offsets on the bus
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_PRESCALE = 8'h0C;
  localparam logic [7:0] OFS_PRECOUNT = 8'h10;
  localparam logic [7:0] OFS_ACTION = 8'h14;
  localparam logic [7:0] OFS_MATCH0 = 8'h18;
  localparam logic [7:0] OFS_MATCH6 = 8'h30;
  localparam logic [7:0] OFS_OUTCFG = 8'h34;
  localparam logic [7:0] OFS_RELEASE = 8'h38;
  localparam logic [7:0] OFS_MASK = 8'h3C;
  localparam logic [7:0] OFS_PINS = 8'h40;
  // control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RST_BIT = 1;
  localparam int CTRL_PWM_BIT = 3;
  // match action fields, three bits per compare register
  localparam int ACT_IRQ = 0;
  localparam int ACT_RST = 1;
  localparam int ACT_STOP = 2;
  localparam int ACT_WIDTH = 3;
  localparam int ACT_BITS = 21;
  // output configuration fields
  localparam int OUTCFG_DBL_LSB = 2;
  localparam int OUTCFG_OE_LSB = 9;
  // values after reset
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [6:0] RST_FLAGS = 7'h00;
endpackage : pwmt_pkg

// File: logic/pwmt_top.sv
// match-based pwm timer with an ahb-lite register slave
// Behaviour
// - 32-bit counter stepped through programmable 32-bit prescaler
// - seven compare registers feed six pwm outputs
// - match may continue, stop or clear, optional irq
// - in pwm mode cycle compare match clears count, sets period
// - single-edge output rises each cycle, falls on match
// - double-edge output: one match rises, other falls
// - period and width any whole number of steps
// - new compare values apply only after software release
// - pwm mode off: plain timer, outputs held low
//
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module pwmt_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  output logic [6:1] pwm_out
);
  pwmt_match_if mif ();

  pwmt_match_bank u_bank (
    .clk(clk),
    .reset_n(reset_n),
    .mif(mif.bank)
  );

  // offset decode shared by the read and write paths
  function automatic logic is_match_ofs(input logic [7:0] a);
    return (a >= pwmt_pkg::OFS_MATCH0) && (a <= pwmt_pkg::OFS_MATCH6);
  endfunction : is_match_ofs

  function automatic logic [2:0] match_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - pwmt_pkg::OFS_MATCH0;
    return d[4:2];
  endfunction : match_idx

  // bus state
  logic take;
  logic [7:0] aofs;
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_ofs_q, wr_ofs_d;
  logic rd_mr_q, rd_mr_d;
  logic [31:0] hrdata_q, hrdata_d;
  // timer state
  logic en_q, en_d, rst_q, rst_d, pwm_en_q, pwm_en_d;
  logic [31:0] tc_q, tc_d, pc_q, pc_d, pr_q, pr_d;
  logic [20:0] mcr_q, mcr_d;
  logic [6:2] dbl_q, dbl_d;
  logic [6:1] oe_q, oe_d;
  logic [6:0] ler_q, ler_d, status_q, status_d, mask_q, mask_d;
  logic [6:1] out_q, out_d;
  // match events
  logic tick, rst_any, stop_any;
  logic [6:0] match, rst_hit, stop_hit, irq_hit, apply;
  logic [6:1] set_e, clr_e;

  // address phase is taken when selected, ready and nonseq/seq
  assign take = hsel & hready & htrans[1];
  assign aofs = haddr[7:0];

  // prescaler wrap yields one count step per programmed period
  assign tick = en_q & ~rst_q & (pc_q == pr_q);

  // per compare register: equality and its programmed actions
  genvar g;
  generate
    for (g = 0; g < pwmt_pkg::NUM_MATCH; g++) begin : g_match
      assign match[g] = tick & (tc_q == mif.active[g]);
      assign irq_hit[g] =
        match[g] & mcr_q[g*pwmt_pkg::ACT_WIDTH + pwmt_pkg::ACT_IRQ];
      assign rst_hit[g] =
        match[g] & mcr_q[g*pwmt_pkg::ACT_WIDTH + pwmt_pkg::ACT_RST];
      assign stop_hit[g] =
        match[g] & mcr_q[g*pwmt_pkg::ACT_WIDTH + pwmt_pkg::ACT_STOP];
    end
  endgenerate

  // in pwm mode the cycle compare always restarts the period
  assign rst_any = (|rst_hit) | (pwm_en_q & match[0]);
  assign stop_any = |stop_hit;

  // edge sources: single-edge uses cycle start, double-edge its pair
  generate
    for (g = 1; g <= pwmt_pkg::NUM_OUT; g++) begin : g_edge
      if (g == 1) begin : g_single
        assign set_e[g] = match[0];
      end else begin : g_either
        assign set_e[g] = dbl_q[g] ? match[g-1] : match[0];
      end
      assign clr_e[g] = match[g];
    end
  endgenerate

  // released values wait for a period start while pwm mode runs
  assign apply = pwm_en_q ? (match[0] ? ler_q : 7'h00) : ler_q;

  assign mif.wr_en = wr_pend_q & is_match_ofs(wr_ofs_q);
  assign mif.wr_idx = match_idx(wr_ofs_q);
  assign mif.wr_data = hwdata;
  assign mif.apply = apply;
  assign mif.rd_idx = is_match_ofs(aofs) ? match_idx(aofs) : 3'h0;

  // next state of bus, timer, flags and outputs
  always_comb begin
    wr_pend_d = take & hwrite;
    wr_ofs_d = aofs;
    rd_mr_d = take & ~hwrite & is_match_ofs(aofs);
    hrdata_d = pwmt_pkg::RST_WORD;
    en_d = en_q;
    rst_d = rst_q;
    pwm_en_d = pwm_en_q;
    tc_d = tc_q;
    pc_d = pc_q;
    pr_d = pr_q;
    mcr_d = mcr_q;
    dbl_d = dbl_q;
    oe_d = oe_q;
    ler_d = ler_q & ~apply;
    status_d = status_q;
    mask_d = mask_q;
    out_d = out_q;
    // count path: prescaler, then main counter, any step size works
    if (en_q && !rst_q) begin
      pc_d = tick ? pwmt_pkg::RST_WORD : pc_q + 32'h0000_0001;
    end
    if (tick) begin
      tc_d = rst_any ? pwmt_pkg::RST_WORD : tc_q + 32'h0000_0001;
    end
    // outputs: clear beats set so equal edges give a constant low
    for (int n = 1; n <= pwmt_pkg::NUM_OUT; n++) begin
      if (!pwm_en_q || !oe_q[n]) begin
        out_d[n] = 1'h0;
      end else if (clr_e[n]) begin
        out_d[n] = 1'h0;
      end else if (set_e[n]) begin
        out_d[n] = 1'h1;
      end
    end
    // data phase writes
    if (wr_pend_q) begin
      case (wr_ofs_q)
        pwmt_pkg::OFS_STATUS: status_d = status_q & ~hwdata[6:0];
        pwmt_pkg::OFS_CTRL: begin
          en_d = hwdata[pwmt_pkg::CTRL_EN_BIT];
          rst_d = hwdata[pwmt_pkg::CTRL_RST_BIT];
          pwm_en_d = hwdata[pwmt_pkg::CTRL_PWM_BIT];
        end
        pwmt_pkg::OFS_COUNT: tc_d = hwdata;
        pwmt_pkg::OFS_PRESCALE: pr_d = hwdata;
        pwmt_pkg::OFS_ACTION: mcr_d = hwdata[pwmt_pkg::ACT_BITS-1:0];
        pwmt_pkg::OFS_OUTCFG: begin
          dbl_d = hwdata[pwmt_pkg::OUTCFG_DBL_LSB +: 5];
          oe_d = hwdata[pwmt_pkg::OUTCFG_OE_LSB +: 6];
        end
        pwmt_pkg::OFS_RELEASE: ler_d = ler_d | hwdata[6:0];
        pwmt_pkg::OFS_MASK: mask_d = hwdata[6:0];
        default: ;
      endcase
    end
    // hardware events win over the software clear and enable
    status_d = status_d | irq_hit;
    if (stop_any) begin
      en_d = 1'h0;
    end
    // held counter reset keeps counts, pending releases and pins cleared
    if (rst_q) begin
      tc_d = pwmt_pkg::RST_WORD;
      pc_d = pwmt_pkg::RST_WORD;
      ler_d = pwmt_pkg::RST_FLAGS;
      out_d = 6'h00;
    end
    // read data built in the address phase so it stands from a flop
    if (take && !hwrite) begin
      case (aofs)
        pwmt_pkg::OFS_STATUS: hrdata_d[6:0] = status_q;
        pwmt_pkg::OFS_CTRL: begin
          hrdata_d[pwmt_pkg::CTRL_EN_BIT] = en_q;
          hrdata_d[pwmt_pkg::CTRL_RST_BIT] = rst_q;
          hrdata_d[pwmt_pkg::CTRL_PWM_BIT] = pwm_en_q;
        end
        pwmt_pkg::OFS_COUNT: hrdata_d = tc_q;
        pwmt_pkg::OFS_PRESCALE: hrdata_d = pr_q;
        pwmt_pkg::OFS_PRECOUNT: hrdata_d = pc_q;
        pwmt_pkg::OFS_ACTION: hrdata_d[pwmt_pkg::ACT_BITS-1:0] = mcr_q;
        pwmt_pkg::OFS_OUTCFG: begin
          hrdata_d[pwmt_pkg::OUTCFG_DBL_LSB +: 5] = dbl_q;
          hrdata_d[pwmt_pkg::OUTCFG_OE_LSB +: 6] = oe_q;
        end
        pwmt_pkg::OFS_RELEASE: hrdata_d[6:0] = ler_q;
        pwmt_pkg::OFS_MASK: hrdata_d[6:0] = mask_q;
        pwmt_pkg::OFS_PINS: hrdata_d[6:1] = out_q;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_q <= 1'h0;
      wr_ofs_q <= 8'h00;
      rd_mr_q <= 1'h0;
      hrdata_q <= pwmt_pkg::RST_WORD;
      en_q <= 1'h0;
      rst_q <= 1'h0;
      pwm_en_q <= 1'h0;
      tc_q <= pwmt_pkg::RST_WORD;
      pc_q <= pwmt_pkg::RST_WORD;
      pr_q <= pwmt_pkg::RST_WORD;
      mcr_q <= 21'h00_0000;
      dbl_q <= 5'h00;
      oe_q <= 6'h00;
      ler_q <= pwmt_pkg::RST_FLAGS;
      status_q <= pwmt_pkg::RST_FLAGS;
      mask_q <= pwmt_pkg::RST_FLAGS;
      out_q <= 6'h00;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_ofs_q <= wr_ofs_d;
      rd_mr_q <= rd_mr_d;
      hrdata_q <= hrdata_d;
      en_q <= en_d;
      rst_q <= rst_d;
      pwm_en_q <= pwm_en_d;
      tc_q <= tc_d;
      pc_q <= pc_d;
      pr_q <= pr_d;
      mcr_q <= mcr_d;
      dbl_q <= dbl_d;
      oe_q <= oe_d;
      ler_q <= ler_d;
      status_q <= status_d;
      mask_q <= mask_d;
      out_q <= out_d;
    end
  end

  // zero wait states, always okay; compare reads come from the bank
  assign hrdata = rd_mr_q ? mif.rd_data : hrdata_q;
  assign hreadyout = 1'h1;
  assign hresp = 1'h0;
  assign irq = |(status_q & mask_q);
  assign pwm_out = out_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  count_step_a: assert property (
    tick && !rst_any && !rst_q && !wr_pend_q |=>
      tc_q == $past(tc_q) + 32'h0000_0001)
    else $error("counter did not step on prescale wrap");
  prescale_wrap_a: assert property (
    en_q && !rst_q && (pc_q == pr_q) |=> pc_q == 32'h0000_0000)
    else $error("prescale counter did not wrap");
  stop_match_a: assert property (
    stop_any |=> !en_q ##1 tc_q == $past(tc_q))
    else $error("counter kept running after stop match");
  flag_set_a: assert property (
    |irq_hit |=> (status_q & $past(irq_hit)) == $past(irq_hit))
    else $error("match interrupt flag not set");
  period_clear_a: assert property (
    pwm_en_q && match[0] && !rst_q && !wr_pend_q |=> tc_q == 32'h0000_0000)
    else $error("cycle compare did not clear the count");
  single_rise_a: assert property (
    pwm_en_q && oe_q[1] && match[0] && !match[1] && !rst_q && !wr_pend_q
      |=> pwm_out[1])
    else $error("single-edge output did not rise at cycle start");
  double_fall_a: assert property (
    match[2] |=> !pwm_out[2])
    else $error("double-edge output did not fall on its match");
  timer_quiet_a: assert property (
    !pwm_en_q |=> pwm_out == 6'h00)
    else $error("pwm output driven with pwm mode off");
  // watch the bank itself, so a stray apply path is caught as well
  release_hold_a: assert property (
    pwm_en_q && !match[0] |=> mif.active == $past(mif.active))
    else $error("compare value applied outside a period start");
  // a period start drains every pending release in pwm mode
  release_apply_a: assert property (
    pwm_en_q && match[0] && !rst_q && !wr_pend_q |=> ler_q == 7'h00)
    else $error("released compare value not applied at period start");
  // with counting off the count holds unless software writes it
  count_hold_a: assert property (
    !en_q && !rst_q && !wr_pend_q |=> tc_q == $past(tc_q))
    else $error("counter moved while counting was off");
  sync_reset_a: assert property (
    rst_q |=> tc_q == 32'h0000_0000 && pc_q == 32'h0000_0000
      && ler_q == 7'h00 && pwm_out == 6'h00)
    else $error("counter reset left state behind");
endmodule : pwmt_top
`default_nettype wire
